// ==== rtl/eee_pkg.sv ====
// package: register map, field positions and carriers for the eee debug bank
package eee_pkg;
  localparam logic [4:0] ADDR_CTRL = 5'h11;
  localparam logic [4:0] ADDR_XID = 5'h12;
  localparam logic [4:0] ADDR_PAGE = 5'h1F;
  localparam logic [4:0] ADDR_BMCR = 5'h00;
  localparam logic [4:0] ADDR_EXT_LO = 5'h10;
  localparam logic [4:0] ADDR_EXT_HI = 5'h1E;
  localparam logic [15:0] PAGE_MAIN = 16'h0000;
  localparam logic [15:0] PAGE_EXT2 = 16'h0002;
  localparam int B_TE_EN = 15;
  localparam int B_RSV14 = 14;
  localparam int B_LED_LO = 10;
  localparam int B_LINK = 8;
  localparam int B_EEE_1G = 7;
  localparam int B_EEE_100 = 6;
  localparam int B_FORCE_1G = 5;
  localparam int B_FORCE_LPI = 4;
  localparam int B_INH_TX100 = 3;
  localparam int B_INH_RX100 = 2;
  localparam int B_INH_TX1G = 1;
  localparam int B_INH_RX1G = 0;
  localparam int B_SPD_MSB = 6;
  localparam int B_SPD_LSB = 13;
  localparam int B_INDUST = 15;
  localparam logic [15:0] CTRL_RW_MASK = 16'hFC3F;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] BMCR_RESET = 16'h0000;
  localparam logic [5:0] XID_RSV = 6'h20;
  localparam logic [1:0] SPD_1000 = 2'h2;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [1:0] SPD_10 = 2'h0;
  // management register access
  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } eee_req_s;
  // lpi steering controls toward the datapath
  typedef struct packed {
    logic te_mode;
    logic force_1g;
    logic gen_lpi;
    logic tx_lpi;
    logic rx_lpi;
  } eee_ctl_s;
endpackage

// ==== rtl/eee_sync.sv ====
// module: two-flop synchroniser for a bus of pin levels
`timescale 1ns/10ps
module eee_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// ==== rtl/eee_regs.sv ====
// module: eee debug control bank with page select and lpi steering
`timescale 1ns/10ps
// How it works
// - ctrl bit 15 runs 10 Mb/s links in reduced-amplitude eee mode.
// - ctrl bits 13:10 invert each led output; default drives active low.
// - bit 10 (led 0) inversion also applies to the serial led output.
// - ctrl bit 7 reads one while gigabit eee is active.
// - ctrl bit 6 reads one while 100 Mb/s eee is active.
// - ctrl bit 5 lets a forced gigabit link rise without master/slave.
// - ctrl bit 4 makes the generator send lpi, ignoring mac data.
// - with bit 4 clear, mac idles pass to the media side.
// - ctrl bit 3 blocks lpi to the media side at 100 Mb/s.
// - ctrl bit 2 blocks lpi to the mac receive side at 100 Mb/s.
// - ctrl bit 1 blocks lpi to the media side at gigabit.
// - ctrl bit 0 blocks lpi to the mac receive side at gigabit.
// - id bit 15 reads one for industrial parts, zero otherwise.
// - id bit 14 reads one and bits 13:10 read zero.
// - writing zero to register 31 returns to the main space.
module eee_regs #(
  parameter logic [7:0] DASH_ID = 8'h00 // arbitrary value
) (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic [4:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  input wire logic SOFT_RST,
  input wire logic INDUSTRIAL,
  input wire logic LINK_UP,
  input wire logic EEE_1G_ACT,
  input wire logic EEE_100_ACT,
  input wire logic [1:0] SPEED,
  input wire logic [3:0] LED_RAW,
  input wire logic LED_SERIAL_RAW,
  input wire logic MAC_TX_LPI,
  input wire logic MDI_RX_LPI,
  output logic [3:0] LED_OUT,
  output logic LED_SERIAL,
  output logic TE_MODE,
  output logic FORCE_1G_LINK,
  output logic GEN_LPI,
  output logic MDI_TX_LPI,
  output logic MAC_RX_LPI
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [12:0] pin_raw;
  logic [12:0] pin_s;
  logic link_s;
  logic eee1g_s;
  logic eee100_s;
  logic indust_s;
  logic [3:0] led_s;
  logic ser_s;
  logic mactx_s;
  logic mdirx_s;

  assign pin_raw = {LINK_UP, EEE_1G_ACT, EEE_100_ACT, INDUSTRIAL, LED_RAW,
                    LED_SERIAL_RAW, MAC_TX_LPI, MDI_RX_LPI, SPEED};

  eee_sync #(.W(13)) u_sync (
    .clk(MCLK),
    .rst_b(RST_B),
    .d(pin_raw),
    .q(pin_s)
  );

  logic [1:0] speed_s;
  assign {link_s, eee1g_s, eee100_s, indust_s, led_s, ser_s, mactx_s,
          mdirx_s, speed_s} = pin_s;

  // ----------------------------------------------------------------
  // register access
  // ----------------------------------------------------------------
  eee_pkg::eee_req_s req;
  assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  logic [15:0] page;
  logic [15:0] ctrl;
  logic [15:0] bmcr;
  logic in_ext;

  function automatic logic ext_hit(input logic [4:0] a,
                                   input logic [15:0] pg);
    ext_hit = (a >= eee_pkg::ADDR_EXT_LO) && (a <= eee_pkg::ADDR_EXT_HI)
              && (pg == eee_pkg::PAGE_EXT2);
  endfunction

  assign in_ext = ext_hit(req.addr, page);

  // page-two decode shared by write and read; reg 0 stays page-free
  function automatic logic page2_hit(input logic [4:0] a,
                                     input logic [15:0] pg,
                                     input logic [4:0] target);
    page2_hit = ext_hit(a, pg) && (a == target);
  endfunction

  // page register; sticky-free, so a software reset returns it to main
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      page <= eee_pkg::PAGE_MAIN;
    end else if (SOFT_RST) begin
      page <= eee_pkg::PAGE_MAIN;
    end else if (req.wr && req.addr == eee_pkg::ADDR_PAGE) begin
      page <= req.wdata;
    end
  end

  // sticky control word ignores software reset
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl <= eee_pkg::CTRL_RESET;
    end else if (req.wr && page2_hit(req.addr, page, eee_pkg::ADDR_CTRL)) begin
      ctrl <= req.wdata & eee_pkg::CTRL_RW_MASK;
    end
  end

  // speed-select bits of register 0; not sticky
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      bmcr <= eee_pkg::BMCR_RESET;
    end else if (SOFT_RST) begin
      bmcr <= eee_pkg::BMCR_RESET;
    end else if (req.wr && req.addr == eee_pkg::ADDR_BMCR) begin
      bmcr <= req.wdata;
    end
  end

  logic [15:0] ctrl_view;
  logic [15:0] xid_view;
  always_comb begin
    ctrl_view = ctrl;
    ctrl_view[eee_pkg::B_LINK] = link_s;
    ctrl_view[eee_pkg::B_EEE_1G] = eee1g_s;
    ctrl_view[eee_pkg::B_EEE_100] = eee100_s;
    xid_view = {indust_s, eee_pkg::XID_RSV, 1'b0, DASH_ID};
  end

  // read data live only in the cycle after the strobe
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      RDATA <= 16'h0000;
    end else if (req.rd) begin
      if (req.addr == eee_pkg::ADDR_PAGE) begin
        RDATA <= page;
      end else if (req.addr == eee_pkg::ADDR_BMCR) begin
        RDATA <= bmcr;
      end else if (page2_hit(req.addr, page, eee_pkg::ADDR_CTRL)) begin
        RDATA <= ctrl_view;
      end else if (page2_hit(req.addr, page, eee_pkg::ADDR_XID)) begin
        RDATA <= xid_view;
      end else begin
        RDATA <= 16'h0000;
      end
    end else begin
      RDATA <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // led polarity
  // ----------------------------------------------------------------
  // raw led inputs are active high requests; default output is active low
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      LED_OUT <= 4'hF;
      LED_SERIAL <= 1'b1;
    end else begin
      LED_OUT <= ~led_s ^ ctrl[eee_pkg::B_LED_LO +: 4];
      // serial stream carries led 0 timing slot polarity
      LED_SERIAL <= ~ser_s ^ ctrl[eee_pkg::B_LED_LO];
    end
  end

  // ----------------------------------------------------------------
  // lpi steering
  // ----------------------------------------------------------------
  eee_pkg::eee_ctl_s next_ctl;
  logic at_1g;
  logic at_100;
  logic [1:0] spd_sel;

  assign spd_sel = {bmcr[eee_pkg::B_SPD_MSB], bmcr[eee_pkg::B_SPD_LSB]};
  assign at_1g = (speed_s == eee_pkg::SPD_1000);
  assign at_100 = (speed_s == eee_pkg::SPD_100);

  always_comb begin
    next_ctl.te_mode = ctrl[eee_pkg::B_TE_EN];
    next_ctl.force_1g = ctrl[eee_pkg::B_FORCE_1G] &&
                        (spd_sel == eee_pkg::SPD_1000);
    next_ctl.gen_lpi = ctrl[eee_pkg::B_FORCE_LPI];
    if (ctrl[eee_pkg::B_FORCE_LPI]) begin
      next_ctl.tx_lpi = 1'b1;
    end else if (at_100 && ctrl[eee_pkg::B_INH_TX100]) begin
      next_ctl.tx_lpi = 1'b0;
    end else if (at_1g && ctrl[eee_pkg::B_INH_TX1G]) begin
      next_ctl.tx_lpi = 1'b0;
    end else begin
      next_ctl.tx_lpi = mactx_s;
    end
    if (at_100 && ctrl[eee_pkg::B_INH_RX100]) begin
      next_ctl.rx_lpi = 1'b0;
    end else if (at_1g && ctrl[eee_pkg::B_INH_RX1G]) begin
      next_ctl.rx_lpi = 1'b0;
    end else begin
      next_ctl.rx_lpi = mdirx_s;
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      TE_MODE <= 1'b0;
      FORCE_1G_LINK <= 1'b0;
      GEN_LPI <= 1'b0;
      MDI_TX_LPI <= 1'b0;
      MAC_RX_LPI <= 1'b0;
    end else begin
      TE_MODE <= next_ctl.te_mode;
      FORCE_1G_LINK <= next_ctl.force_1g;
      GEN_LPI <= next_ctl.gen_lpi;
      MDI_TX_LPI <= next_ctl.tx_lpi;
      MAC_RX_LPI <= next_ctl.rx_lpi;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);

  chk_te_follow: assert property (
    TE_MODE == $past(ctrl[eee_pkg::B_TE_EN]))
    else $error("te mode not following ctrl bit 15");
  chk_led_pol: assert property (
    LED_OUT == ($past(~led_s) ^ $past(ctrl[13:10])))
    else $error("led polarity wrong");
  chk_ser_pol: assert property (
    LED_SERIAL == ($past(~ser_s) ^ $past(ctrl[eee_pkg::B_LED_LO])))
    else $error("serial led polarity wrong");
  chk_link_read: assert property (
    (RD && in_ext && ADDR == eee_pkg::ADDR_CTRL) |=>
      RDATA[8] == $past(link_s) && RDATA[7] == $past(eee1g_s))
    else $error("status bits misread");
  chk_force_lpi: assert property (
    ctrl[eee_pkg::B_FORCE_LPI] |=> MDI_TX_LPI && GEN_LPI)
    else $error("forced lpi not sent");
  chk_inh_tx: assert property (
    (at_1g && ctrl[1] && !ctrl[4]) |=> !MDI_TX_LPI)
    else $error("gigabit tx lpi not inhibited");
  chk_inh_rx: assert property (
    (at_100 && ctrl[2]) |=> !MAC_RX_LPI)
    else $error("100 rx lpi not inhibited");
  chk_sticky_soft: assert property (
    (SOFT_RST && !WR) |=> ctrl == $past(ctrl))
    else $error("sticky bits lost on soft reset");
  chk_xid_fixed: assert property (
    (RD && in_ext && ADDR == eee_pkg::ADDR_XID) |=>
      RDATA[15:10] == {$past(indust_s), 5'h10})
    else $error("id bits wrong");
  chk_page_gate: assert property (
    (RD && page != eee_pkg::PAGE_EXT2 && ADDR == eee_pkg::ADDR_CTRL)
      |=> RDATA == 16'h0000)
    else $error("page gating broken");

  // ----------------------------------------------------------------
  // management path checks
  // ----------------------------------------------------------------
  // read checks look one cycle on, where read data stand
  chk_eee100_read: assert property (
    (RD && in_ext && ADDR == eee_pkg::ADDR_CTRL) |=>
      RDATA[eee_pkg::B_EEE_100] == $past(eee100_s))
    else $error("100 mb/s eee status misread");
  chk_indust_read: assert property (
    (RD && in_ext && ADDR == eee_pkg::ADDR_XID) |=>
      RDATA[eee_pkg::B_INDUST] == $past(indust_s))
    else $error("temperature grade misread");
  chk_xid_low: assert property (
    (RD && in_ext && ADDR == eee_pkg::ADDR_XID) |=>
      RDATA[9:0] == {2'h0, DASH_ID})
    else $error("id low bits wrong");
  chk_page_read: assert property (
    (RD && ADDR == eee_pkg::ADDR_PAGE) |=> RDATA == $past(page))
    else $error("page register misread");
  chk_ctrl_gate: assert property (
    (WR && !in_ext && ADDR == eee_pkg::ADDR_CTRL) |=> $stable(ctrl))
    else $error("control written outside page two");
  chk_page_main: assert property (
    (WR && ADDR == eee_pkg::ADDR_PAGE && WDATA == eee_pkg::PAGE_MAIN)
      |=> page == eee_pkg::PAGE_MAIN)
    else $error("page not returned to main space");
  // soft reset clears only the non-sticky page and speed select
  chk_soft_page: assert property (
    SOFT_RST |=> page == eee_pkg::PAGE_MAIN)
    else $error("page survived soft reset");
  chk_bmcr_soft: assert property (
    SOFT_RST |=> bmcr == eee_pkg::BMCR_RESET)
    else $error("speed select survived soft reset");

  // ----------------------------------------------------------------
  // lpi steering checks
  // ----------------------------------------------------------------
  // forced lpi outranks the transmit inhibits, so each transmit inhibit check excludes it
  chk_force_link: assert property (
    FORCE_1G_LINK == ($past(ctrl[eee_pkg::B_FORCE_1G]) &&
      ($past(spd_sel) == eee_pkg::SPD_1000)))
    else $error("gigabit force mode wrong");
  chk_mac_idle: assert property (
    (!ctrl[eee_pkg::B_FORCE_LPI] && !ctrl[eee_pkg::B_INH_TX100] &&
      !ctrl[eee_pkg::B_INH_TX1G]) |=> MDI_TX_LPI == $past(mactx_s))
    else $error("mac idles not forwarded");
  chk_gen_clear: assert property (
    !ctrl[eee_pkg::B_FORCE_LPI] |=> !GEN_LPI)
    else $error("generator left on");
  chk_inh_tx100: assert property (
    (at_100 && ctrl[eee_pkg::B_INH_TX100] && !ctrl[eee_pkg::B_FORCE_LPI])
      |=> !MDI_TX_LPI)
    else $error("100 mb/s tx lpi not inhibited");
  chk_rx_pass: assert property (
    (!ctrl[eee_pkg::B_INH_RX100] && !ctrl[eee_pkg::B_INH_RX1G]) |=>
      MAC_RX_LPI == $past(mdirx_s))
    else $error("media lpi not passed to mac");
  chk_inh_rx1g: assert property (
    (at_1g && ctrl[eee_pkg::B_INH_RX1G]) |=> !MAC_RX_LPI)
    else $error("gigabit rx lpi not inhibited");

  // main scenarios

  cov_ext_read: cover property (RD && in_ext && ADDR == eee_pkg::ADDR_CTRL);
  cov_force: cover property (GEN_LPI ##1 !GEN_LPI);
  cov_force_1g: cover property (FORCE_1G_LINK);
  cov_soft_rst: cover property (SOFT_RST ##1 page == eee_pkg::PAGE_MAIN);
  cov_rx_block: cover property ((at_1g && mdirx_s) ##1 !MAC_RX_LPI);
endmodule

// ==== test/eee_far_end.sv ====
// far-end model: mac, media and board pins that feed the bank
`timescale 1ns/10ps
module eee_far_end (
  input wire logic MCLK,
  input wire logic [12:0] want,
  output logic [12:0] pins
);
  // speed 11 is no real mode, so the far end never shows it
  always_ff @(posedge MCLK) begin
    pins <= {want[12:9], (want[8:7] == 2'h3) ? 2'h2 : want[8:7], want[6:0]};
  end
endmodule

// ==== test/eee_debug_control_regs_bench.sv ====
// self-checking bench for the eee debug control bank
`timescale 1ns/10ps
module eee_debug_control_regs_bench;
  logic MCLK, RST_B, WR, RD, SOFT_RST;
  logic [4:0] ADDR;
  logic [15:0] WDATA, RDATA, c_m, r0_m;
  logic [12:0] want, w, p;
  logic [9:0] outs;
  int err_total, compares;
  // ----------------------------------------
  // design and far end
  // ----------------------------------------
  eee_far_end eee_far_end_inst (.MCLK(MCLK), .want(want), .pins(p));
  eee_regs eee_regs_inst (.MCLK(MCLK), .RST_B(RST_B), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SOFT_RST(SOFT_RST),
    .INDUSTRIAL(p[12]), .LINK_UP(p[11]), .EEE_1G_ACT(p[10]),
    .EEE_100_ACT(p[9]), .SPEED(p[8:7]), .LED_RAW(p[6:3]),
    .LED_SERIAL_RAW(p[2]), .MAC_TX_LPI(p[1]), .MDI_RX_LPI(p[0]),
    .LED_OUT(outs[9:6]), .LED_SERIAL(outs[5]), .TE_MODE(outs[4]),
    .FORCE_1G_LINK(outs[3]), .GEN_LPI(outs[2]), .MDI_TX_LPI(outs[1]),
    .MAC_RX_LPI(outs[0]));
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end
  // ----------------------------------------
  // model and checks
  // ----------------------------------------
  function automatic logic [15:0] exp_ctrl();
    return (c_m & eee_pkg::CTRL_RW_MASK) | {7'h00, want[11:9], 6'h00};
  endfunction
  function automatic logic [9:0] exp_pins();
    logic g, h, itx, irx;
    g = want[8:7] == eee_pkg::SPD_1000;
    h = want[8:7] == eee_pkg::SPD_100;
    itx = (g & c_m[1]) | (h & c_m[3]);
    irx = (g & c_m[0]) | (h & c_m[2]);
    // forced lpi wins over the transmit inhibits
    return {~want[6:3] ^ c_m[13:10], ~want[2] ^ c_m[10], c_m[15],
      c_m[5] & r0_m[6] & ~r0_m[13], c_m[4], c_m[4] | (want[1] & ~itx),
      want[0] & ~irx};
  endfunction
  task automatic cmp_word(input logic [15:0] exp);
    compares++;
    if (RDATA !== exp) begin
      err_total++;
      $display("unexpected read data: expected %h seen %h", exp, RDATA);
    end
  endtask
  task automatic cmp_pins(input logic [9:0] exp);
    compares++;
    if (outs !== exp) begin
      err_total++;
      $display("unexpected control pins: expected %h seen %h", exp, outs);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    #1;
    cmp_word(exp);
  endtask
  // pins pass two sync flops and an output flop
  task automatic settle();
    repeat (5) @(posedge MCLK);
    #1;
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (5000) @(posedge MCLK);
    err_total++;
    end_of_test();
  end
  initial begin
    {RST_B, WR, RD, SOFT_RST, ADDR, WDATA, want, w} = '0;
    {c_m, r0_m, err_total, compares} = '0;
    void'($urandom(38));
    repeat (8) @(posedge MCLK);
    RST_B <= 1'b1;
    settle();
    cmp_pins(exp_pins());
    rd(eee_pkg::ADDR_CTRL, 16'h0000);
    wr(eee_pkg::ADDR_PAGE, eee_pkg::PAGE_EXT2);
    rd(eee_pkg::ADDR_CTRL, exp_ctrl());
    rd(5'h13, 16'h0000);
    $display("reset and page test done");
    for (int i = 0; i < 40; i++) begin
      w = 13'($urandom);
      w[8:7] = 2'($urandom_range(2));
      c_m = 16'($urandom);
      r0_m = 16'($urandom);
      @(posedge MCLK);
      want <= w;
      wr(eee_pkg::ADDR_BMCR, r0_m);
      wr(eee_pkg::ADDR_CTRL, c_m);
      settle();
      cmp_pins(exp_pins());
      cmp_pins(exp_pins());
      rd(eee_pkg::ADDR_CTRL, exp_ctrl());
      rd(eee_pkg::ADDR_XID, {want[12], 6'h20, 9'h000});
    end
    $display("random control test done");
    @(posedge MCLK);
    SOFT_RST <= 1'b1;
    @(posedge MCLK);
    SOFT_RST <= 1'b0;
    r0_m = 16'h0000;
    rd(eee_pkg::ADDR_PAGE, eee_pkg::PAGE_MAIN);
    wr(eee_pkg::ADDR_PAGE, eee_pkg::PAGE_EXT2);
    rd(eee_pkg::ADDR_CTRL, exp_ctrl());
    settle();
    cmp_pins(exp_pins());
    $display("soft reset test done");
    c_m[4] = 1'b0;
    wr(eee_pkg::ADDR_CTRL, c_m);
    wr(eee_pkg::ADDR_PAGE, eee_pkg::PAGE_MAIN);
    wr(eee_pkg::ADDR_CTRL, 16'hFFFF);
    rd(eee_pkg::ADDR_CTRL, 16'h0000);
    wr(eee_pkg::ADDR_PAGE, eee_pkg::PAGE_EXT2);
    rd(eee_pkg::ADDR_CTRL, exp_ctrl());
    @(posedge MCLK);
    RST_B <= 1'b0;
    @(posedge MCLK);
    RST_B <= 1'b1;
    c_m = 16'h0000;
    wr(eee_pkg::ADDR_PAGE, eee_pkg::PAGE_EXT2);
    rd(eee_pkg::ADDR_CTRL, exp_ctrl());
    $display("page return and hard reset test done");
    end_of_test();
  end
endmodule
